// file: rtl/slb_lowpower_break.sv
// low-power sequencing, break flag protection and status registers
`timescale 1ns/1ps
// Functional notes
// - clear-enable zero in break protects flags
// - clear-enable one allows normal flag clearing
// - flags cleared in break stay cleared
// - two-step clears protected, finish after break
// - wait/stop clear interrupt mask, stop processor
// - wait gates processor clock, peripherals run
// - wait wake stacking starts one cycle later
// - reset or break ends wait, sets flag
// - watchdog active in wait unless disabled
// - stop resets counter, disables clock output
// - stop exits; stacking after recovery time
// - recovery 4096 or 32 oscillator cycles
// - break in stop sets break-exit flag
// - counter held until recovery, then times
// - three registers at fixed addresses
// - break-exit flag set, write-zero/reset clear
// - reading cause register clears; POR sets only POR
// - cause flag set for last reset source
// - bad-address flag for opcode fetches only
// - monitor flag on blank vector, pin high
// - break forces software-interrupt vector
module slb_lowpower_break #(
	parameter int STOP_REC_LONG_CYC = slb_pkg::STOP_REC_LONG,
	parameter int STOP_REC_SHORT_CYC = slb_pkg::STOP_REC_SHORT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic icClkTick,
	input wire logic porEvent,
	input wire slb_pkg::slb_cause_t resetCause,
	input wire logic badAddrIsFetch,
	input wire logic [7:0] vectorHi,
	input wire logic [7:0] vectorLo,
	input wire logic extIntPinHigh,
	input wire logic shortStopRecovery,
	input wire logic watchdogDisable,
	input wire logic waitExec,
	input wire logic stopExec,
	input wire logic moduleIrq,
	input wire logic breakReq,
	input wire logic [15:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic cpuClkEn,
	output logic periphClkEn,
	output logic clearIntMask,
	output logic stackStart,
	output logic forceSwiVector,
	output logic flagClearAllow,
	output logic watchdogRun
);
	import slb_pkg::*;

	// ************************************************
	// bus decode
	// ************************************************
	logic accessPhase;
	logic wrBrk, wrCtrl, rdCause, hit;
	assign accessPhase = psel && penable;
	assign hit = (paddr == BRK_STATUS_ADDR) || (paddr == RST_CAUSE_ADDR) || (paddr == BRK_FLAG_CTRL_ADDR);
	assign wrBrk = accessPhase && pwrite && (paddr == BRK_STATUS_ADDR);
	assign wrCtrl = accessPhase && pwrite && (paddr == BRK_FLAG_CTRL_ADDR);
	assign rdCause = accessPhase && !pwrite && (paddr == RST_CAUSE_ADDR);

	// ************************************************
	// power state machine
	// ************************************************
	slb_pstate_t pState_q;
	logic breakActive_q;
	logic [REC_CNT_W-1:0] recCnt_q;
	logic recDone;
	logic [REC_CNT_W-1:0] recTarget;
	logic breakExitEv;
	assign recTarget = shortStopRecovery ? REC_CNT_W'(STOP_REC_SHORT_CYC - 1) : REC_CNT_W'(STOP_REC_LONG_CYC - 1);
	assign recDone = (pState_q == PS_RECOVER) && icClkTick && (recCnt_q == recTarget);
	// break ends wait or stop; only at the exit itself, so a held
	// break during recovery cannot re-set a flag that software cleared
	assign breakExitEv = breakReq && ((pState_q == PS_WAIT) || (pState_q == PS_STOP));

	// state transitions; reset itself is the exit on reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pState_q <= PS_RUN;
		end else begin
			unique case (pState_q)
				PS_RUN: begin
					if (stopExec) begin
						pState_q <= PS_STOP;
					end else if (waitExec) begin
						pState_q <= PS_WAIT;
					end
				end
				PS_WAIT: begin
					if (moduleIrq || breakReq) begin
						pState_q <= PS_RUN;
					end
				end
				PS_STOP: begin
					if (moduleIrq || breakReq) begin
						pState_q <= PS_RECOVER;
					end
				end
				PS_RECOVER: begin
					if (recDone) begin
						pState_q <= PS_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			recCnt_q <= '0;
		end else if (pState_q != PS_RECOVER) begin
			recCnt_q <= '0; // also reset on stop entry
		end else if (icClkTick) begin
			recCnt_q <= recCnt_q + REC_CNT_W'(1);
		end
	end

	// clock gating and mask clear, registered outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpuClkEn <= 1'b1;
			periphClkEn <= 1'b1;
			clearIntMask <= 1'b0;
			watchdogRun <= 1'b0;
		end else begin
			// mask clear on wait or stop
			clearIntMask <= (pState_q == PS_RUN) && (waitExec || stopExec);
			cpuClkEn <= (pState_q == PS_RUN) ? !(waitExec || stopExec) :
				((pState_q == PS_WAIT) && (moduleIrq || breakReq)) || recDone;
			periphClkEn <= (pState_q == PS_RUN) ? !stopExec :
				(pState_q == PS_WAIT) || recDone;
			watchdogRun <= !watchdogDisable && (pState_q != PS_STOP) && (pState_q != PS_RECOVER);
		end
	end

	// stacking strobe, one pulse per wake, none while break is held
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stackStart <= 1'b0;
		end else begin
			stackStart <= ((pState_q == PS_WAIT) && moduleIrq && !breakReq) || (recDone && !breakActive_q);
		end
	end

	// ************************************************
	// break state and flag protection
	// ************************************************
	logic breakClearEn_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			breakActive_q <= 1'b0;
			forceSwiVector <= 1'b0;
		end else begin
			breakActive_q <= breakReq;
			forceSwiVector <= breakReq && !breakActive_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			breakClearEn_q <= BRK_FLAG_CTRL_RST[BREAK_CLEAR_EN_BIT];
		end else if (wrCtrl) begin
			breakClearEn_q <= pwdata[BREAK_CLEAR_EN_BIT];
		end
	end

	// qualifier seen by peripherals at each clearing access; a flag that
	// is cleared stays cleared because nothing here restores it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flagClearAllow <= 1'b1;
		end else begin
			flagClearAllow <= !breakReq || breakClearEn_q;
		end
	end

	// ************************************************
	// status registers
	// ************************************************
	logic breakExit_q;
	logic [7:0] causeReg_q;
	logic monitorEntry;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			breakExit_q <= BRK_STATUS_RST[BREAK_EXIT_BIT];
		end else if (breakExitEv) begin
			breakExit_q <= 1'b1;
		end else if (wrBrk && !pwdata[BREAK_EXIT_BIT]) begin
			breakExit_q <= 1'b0;
		end
	end

	assign monitorEntry = resetCause.monitorEntry && (vectorHi == BLANK_VECTOR) &&
		(vectorLo == BLANK_VECTOR) && extIntPinHigh;

	// causes are presented for one clock after release; power-on loads RST_CAUSE_POR_VAL, a read of it or rst_n clears the register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			causeReg_q <= 8'h00;
		end else if (porEvent || resetCause.por) begin
			causeReg_q <= RST_CAUSE_POR_VAL;
		end else if (resetCause != '0) begin
			causeReg_q[CAUSE_PIN_BIT] <= causeReg_q[CAUSE_PIN_BIT] | resetCause.pin;
			causeReg_q[CAUSE_WDOG_BIT] <= causeReg_q[CAUSE_WDOG_BIT] | resetCause.wdog;
			causeReg_q[CAUSE_BADOP_BIT] <= causeReg_q[CAUSE_BADOP_BIT] | resetCause.badOpcode;
			causeReg_q[CAUSE_BADADDR_BIT] <= causeReg_q[CAUSE_BADADDR_BIT] |
				(resetCause.badAddrFetch && badAddrIsFetch);
			causeReg_q[CAUSE_MON_BIT] <= causeReg_q[CAUSE_MON_BIT] | monitorEntry;
			causeReg_q[CAUSE_LOWV_BIT] <= causeReg_q[CAUSE_LOWV_BIT] | resetCause.lowVoltage;
		end else if (rdCause) begin
			causeReg_q <= 8'h00;
		end
	end

	// ************************************************
	// apb slave, zero wait states
	// ************************************************
	// eight bits, others zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !hit;
			prdata <= '0;
			if (psel && !penable && !pwrite) begin
				if (paddr == BRK_STATUS_ADDR) begin
					prdata[BREAK_EXIT_BIT] <= breakExit_q;
				end else if (paddr == RST_CAUSE_ADDR) begin
					prdata[7:0] <= causeReg_q;
				end else if (paddr == BRK_FLAG_CTRL_ADDR) begin
					prdata[BREAK_CLEAR_EN_BIT] <= breakClearEn_q;
				end
			end
		end
	end
endmodule : slb_lowpower_break

// file: rtl/slb_pkg.sv
// package: register map, field layout and timing constants of the low-power/break status block
package slb_pkg;
	// byte addresses of the three registers
	localparam logic [15:0] BRK_STATUS_ADDR = 16'hFE00;
	localparam logic [15:0] RST_CAUSE_ADDR = 16'hFE01;
	localparam logic [15:0] BRK_FLAG_CTRL_ADDR = 16'hFE03;
	// field positions
	localparam int BREAK_EXIT_BIT = 1;
	localparam int BREAK_CLEAR_EN_BIT = 7;
	localparam int CAUSE_POR_BIT = 7;
	localparam int CAUSE_PIN_BIT = 6;
	localparam int CAUSE_WDOG_BIT = 5;
	localparam int CAUSE_BADOP_BIT = 4;
	localparam int CAUSE_BADADDR_BIT = 3;
	localparam int CAUSE_MON_BIT = 2;
	localparam int CAUSE_LOWV_BIT = 1;
	// reset values
	localparam logic [7:0] BRK_STATUS_RST = 8'h00;
	localparam logic [7:0] BRK_FLAG_CTRL_RST = 8'h00;
	localparam logic [7:0] RST_CAUSE_POR_VAL = 8'h80;
	// vector byte value for blank reset vector
	localparam logic [7:0] BLANK_VECTOR = 8'hFF;
	// stop recovery lengths in oscillator cycles
	localparam int STOP_REC_LONG = 4096;
	localparam int STOP_REC_SHORT = 32;
	localparam int REC_CNT_W = 13;
	// reset causes reported with a reset event
	typedef struct packed {
		logic por;
		logic pin;
		logic wdog;
		logic badOpcode;
		logic badAddrFetch;
		logic monitorEntry;
		logic lowVoltage;
	} slb_cause_t;
	// power state
	typedef enum logic [1:0] {PS_RUN, PS_WAIT, PS_STOP, PS_RECOVER} slb_pstate_t;
endpackage : slb_pkg

// file: testbench/slb_osc_model.sv
// partner: free-running internal oscillator tick source
`timescale 1ns/1ps
module slb_osc_model #(
	parameter int DIV = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	output logic icClkTick
);
	// ****
	// oscillator tick
	// ****
	int cnt_q;
	// one tick every DIV bus cycles; it runs free, in stop too, as a real oscillator
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 0;
			icClkTick <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == DIV - 1) ? 0 : cnt_q + 1;
			icClkTick <= (cnt_q == DIV - 1);
		end
	end
endmodule : slb_osc_model

// file: testbench/slb_lowpower_break_sva.sv
// checker: port-level assertions for the low-power and break block
`timescale 1ns/1ps
module slb_lowpower_break_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic waitExec,
	input wire logic stopExec,
	input wire logic moduleIrq,
	input wire logic breakReq,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cpuClkEn,
	input wire logic periphClkEn,
	input wire logic clearIntMask,
	input wire logic stackStart,
	input wire logic forceSwiVector
);
	// ****
	// assertions
	// ****
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_apb_ready_next:
	assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_ready_one_cycle:
	assert property (pready |=> !pready) else $error("ready held too long");
	a_err_with_ready:
	assert property (pslverr |-> pready) else $error("error without ready");
	a_wait_entry_gates:
	assert property (cpuClkEn && periphClkEn && waitExec && !stopExec && !moduleIrq && !breakReq
		|=> !cpuClkEn && periphClkEn && clearIntMask) else $error("wait entry wrong");
	a_stop_entry_gates:
	assert property (cpuClkEn && periphClkEn && stopExec && !waitExec && !moduleIrq && !breakReq
		|=> !cpuClkEn && !periphClkEn && clearIntMask) else $error("stop entry wrong");
	a_wait_irq_wake:
	assert property (!cpuClkEn && periphClkEn && moduleIrq && !breakReq |=> cpuClkEn && stackStart)
		else $error("wait wake late");
	a_no_stack_stopped:
	assert property (!periphClkEn |-> !stackStart) else $error("stacking while stopped");
	a_break_swi_vector:
	assert property ($rose(breakReq) |=> forceSwiVector) else $error("no vector force on break");
	a_stack_one_pulse:
	assert property (stackStart |=> !stackStart) else $error("stack start too long");
	// main scenarios reached
	cover property (waitExec ##1 !cpuClkEn);
	cover property (!periphClkEn ##1 periphClkEn);
	cover property (pslverr);
endmodule : slb_lowpower_break_chk

// file: testbench/slb_lowpower_break_test.sv
// testbench: scenario tasks for the low-power and break block
`timescale 1ns/1ps
module slb_lowpower_break_test;
	import slb_pkg::*;
	localparam int LONG_N = 64;
	logic clk, rst_n, icClkTick, porEvent, badAddrIsFetch, extIntPinHigh, shortStopRecovery, watchdogDisable;
	logic waitExec, stopExec, moduleIrq, breakReq, psel, penable, pwrite, pready, pslverr, er;
	logic cpuClkEn, periphClkEn, clearIntMask, stackStart, forceSwiVector, flagClearAllow, watchdogRun;
	logic [7:0] vectorHi, vectorLo, rd;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	slb_cause_t resetCause;
	int bad_count, n_tests;
	// long recovery shortened so the stop runs stay brief
	slb_lowpower_break #(.STOP_REC_LONG_CYC(LONG_N)) i_slb_lowpower_break (.clk, .rst_n, .icClkTick, .porEvent,
		.resetCause, .badAddrIsFetch, .vectorHi, .vectorLo, .extIntPinHigh, .shortStopRecovery, .watchdogDisable,
		.waitExec, .stopExec, .moduleIrq, .breakReq, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .cpuClkEn, .periphClkEn, .clearIntMask, .stackStart, .forceSwiVector, .flagClearAllow, .watchdogRun);
	slb_osc_model i_slb_osc_model (.clk(clk), .rst_n(rst_n), .icClkTick(icClkTick));
	// ****
	// shared tasks
	// ****
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task automatic finish_test();
		if (bad_count == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic timeout_hit();
		bad_count++;
		$display("BAD %0t timeout", $time);
		finish_test();
	endtask : timeout_hit
	// apb transfer; request held until ready is sampled high, one idle edge after
	task automatic apb(input logic [15:0] a, input logic w, input logic [7:0] d, output logic [7:0] r, output logic e);
		int k;
		k = 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		psel <= 1'b1;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) timeout_hit();
		r = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	// ****
	// scenarios
	// ****
	task automatic t_regs();
		apb(RST_CAUSE_ADDR, 0, 0, rd, er);
		chk(rd, RST_CAUSE_POR_VAL);
		apb(RST_CAUSE_ADDR, 0, 0, rd, er);
		chk(rd, 8'h00);
		apb(BRK_STATUS_ADDR, 0, 0, rd, er);
		chk(rd, BRK_STATUS_RST);
		apb(BRK_FLAG_CTRL_ADDR, 1, 8'hFF, rd, er);
		apb(BRK_FLAG_CTRL_ADDR, 0, 0, rd, er);
		chk(rd, 8'h80);
		apb(BRK_FLAG_CTRL_ADDR, 1, 8'h00, rd, er);
		apb(16'hFE02, 0, 0, rd, er);
		chk({7'h0, er}, 8'h01);
	endtask : t_regs
	task automatic t_cause();
		for (int i = 0; i < 7; i++) begin
			resetCause <= slb_cause_t'(7'h01 << i);
			@(posedge clk);
			resetCause <= '0;
			@(posedge clk);
			apb(RST_CAUSE_ADDR, 0, 0, rd, er);
			chk(rd, 8'h02 << i);
		end
	endtask : t_cause
	task automatic t_wait();
		waitExec <= 1'b1;
		@(posedge clk);
		waitExec <= 1'b0;
		@(posedge clk);
		chk({4'h0, cpuClkEn, periphClkEn, clearIntMask, watchdogRun}, 8'h07);
		moduleIrq <= 1'b1;
		@(posedge clk);
		moduleIrq <= 1'b0;
		@(posedge clk);
		chk({6'h0, cpuClkEn, stackStart}, 8'h03);
	endtask : t_wait
	// break in wait (m=0) then in stop (m=1); clear the flag while break still stands
	task automatic t_break();
		int k;
		for (int m = 0; m < 2; m++) begin
			@(posedge clk);
			waitExec <= (m == 0);
			stopExec <= (m == 1);
			@(posedge clk);
			waitExec <= 1'b0;
			stopExec <= 1'b0;
			@(posedge clk);
			breakReq <= 1'b1;
			@(posedge clk);
			@(posedge clk);
			chk({6'h0, forceSwiVector, flagClearAllow}, 8'h02);
			apb(BRK_STATUS_ADDR, 0, 0, rd, er);
			chk(rd, 8'h02);
			apb(BRK_FLAG_CTRL_ADDR, 1, 8'h80, rd, er);
			@(posedge clk);
			chk({7'h0, flagClearAllow}, 8'h01);
			apb(BRK_FLAG_CTRL_ADDR, 1, 8'h00, rd, er);
			apb(BRK_STATUS_ADDR, 1, 8'h00, rd, er);
			breakReq <= 1'b0;
			apb(BRK_STATUS_ADDR, 0, 0, rd, er);
			chk(rd, 8'h00);
			k = 0;
			while (cpuClkEn !== 1'b1 && k < 2000) begin
				@(posedge clk);
				k++;
			end
			if (k >= 2000) timeout_hit();
		end
	endtask : t_break
	task automatic t_stop(input logic sh);
		int k, t, n;
		@(posedge clk);
		shortStopRecovery <= sh;
		stopExec <= 1'b1;
		@(posedge clk);
		stopExec <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		chk({6'h0, cpuClkEn, periphClkEn}, 8'h00);
		moduleIrq <= 1'b1;
		k = 0;
		t = 0;
		while (stackStart !== 1'b1 && k < 2000) begin
			@(posedge clk);
			k++;
			if (icClkTick === 1'b1) t++;
		end
		moduleIrq <= 1'b0;
		if (k >= 2000) timeout_hit();
		n = sh ? STOP_REC_SHORT : LONG_N;
		chk({7'h0, t >= n && t <= n + 2}, 8'h01);
	endtask : t_stop
	initial begin
		{rst_n, porEvent, shortStopRecovery, watchdogDisable, waitExec, stopExec, moduleIrq, breakReq} = '0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		resetCause = '0;
		{badAddrIsFetch, extIntPinHigh, vectorHi, vectorLo} = {2'b11, BLANK_VECTOR, BLANK_VECTOR};
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		porEvent <= 1'b1;
		@(posedge clk);
		porEvent <= 1'b0;
		@(posedge clk);
		t_regs();
		t_cause();
		t_wait();
		t_break();
		t_stop(1'b0);
		t_stop(1'b1);
		finish_test();
	end
endmodule : slb_lowpower_break_test
bind slb_lowpower_break slb_lowpower_break_chk i_slb_lowpower_break_chk (.clk, .rst_n, .waitExec, .stopExec,
	.moduleIrq, .breakReq, .psel, .penable, .pready, .pslverr, .cpuClkEn, .periphClkEn, .clearIntMask,
	.stackStart, .forceSwiVector);
